// *** core/smcd_ctrl.sv ***
// Sector map configuration detector: walks the sector map table in the
// flash, runs each detection command and builds the selector.
// Assumes an AHB-Lite master on the CLK domain and a serial flash on the
// FL_ pins, single data line, clock idle low.
`timescale 1ns/1ps
`include "smcd_defs.svh"

// Overview of operation
// R1 - Header word two bits 31:24 must be FFh; else reported as an error.
// R2 - Bits 23:0 give table start byte address, DWORD aligned.
// R3 - A single configuration may have no detection command descriptors.
// R4 - More than two configurations need more than one command descriptor.
// R5 - Command descriptors precede maps; the first map ends the command list.
// R6 - Each command descriptor is two words; pointer advances by two words.
// R7 - Each detection command reads one register byte, no mode bits.
// R8 - One detection command sent per configuration bit, from its descriptor.
// R9 - One-hot mask in bits 31:24 ANDed with data isolates the bit.
// R10 - Address length 00 none, 01 three bytes, 10 four bytes.
// R11 - Address length 11 uses the address mode last configured.
// R12 - Reserved bits 21:20 and 7:2 of word one read as ones.
// R13 - Bits 19:16 give 0 to 14 wait cycles before the data byte.
// R14 - Latency Fh uses the wait count last configured in the memory.
// R15 - Bits 15:8 hold the opcode sent as the command instruction.
// R16 - Bit 1 of word one: 0 command descriptor, 1 map descriptor.
// R17 - Bit 0 of word one: 1 marks the last descriptor of its type.
// R18 - Word two holds the address; only selected bytes are sent.
// R19 - Detected bits shift in from the right; selector at most 8 bits.
// R20 - With no command descriptors the selector is zero.
// R21 - Opcode, address MSB first, wait cycles, then one data byte.
module smcd_ctrl #(
	parameter int SCK_HALF = 4,
	parameter int CS_GAP   = `SMCD_CS_GAP_CYC
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic [31:0]      HRDATA,
	// Serial flash
	output logic             FL_SCK,
	output logic             FL_CSN,
	output logic             FL_MOSI,
	input  wire logic        FL_MISO
);

	smcd_pkg::smcd_state_t st_r;
	logic [31:0] hdr2_r;
	logic [31:0] cfg_r;
	logic [31:0] rdata_r;
	logic [7:0]  wa_r;
	logic        wpend_r;
	logic        kind_r;
	logic        wsel_r;
	logic        wait_r;
	logic        csn_r;
	logic [7:0]  op_r;
	logic [31:0] ash_r;
	logic [2:0]  nadr_r;
	logic [3:0]  ndum_r;
	logic [2:0]  ndat_r;
	logic [2:0]  bcnt_r;
	logic [31:0] word_r;
	logic [31:0] desc_r;
	logic [23:0] ptr_r;
	logic [7:0]  sel_r;
	logic [3:0]  cnt_r;
	logic        last_r;
	logic [7:0]  gap_r;
	logic [7:0]  lastb_r;
	logic        done_r;
	logic        err_id_r;
	logic        err_al_r;
	logic        err_ord_r;
	logic        err_ovf_r;
	logic        wmask_r;
	logic        wrsv_r;
	logic        spi_done;
	logic [7:0]  spi_rx;

	////////////////////////////////////////////////////////////////////////
	// Decoding functions
	function automatic logic [2:0] alen_bytes(input logic [1:0] code,
	                                          input logic       addr4);
		unique case (code)
			`SMCD_ALEN_NONE: alen_bytes = 3'd0;
			`SMCD_ALEN_3:    alen_bytes = 3'd3;
			`SMCD_ALEN_4:    alen_bytes = 3'd4;
			default:         alen_bytes = addr4 ? 3'd4 : 3'd3; // R11
		endcase
	endfunction

	function automatic logic onehot8(input logic [7:0] v);
		onehot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire        ahb_acc = HSEL & HREADY & HTRANS[1];
	wire        wr_ctrl = wpend_r & (wa_r == `SMCD_OFS_CTRL);
	wire        wr_hdr2 = wpend_r & (wa_r == `SMCD_OFS_HDR2);
	wire        wr_cfg  = wpend_r & (wa_r == `SMCD_OFS_CFG);
	wire        busy    = (st_r != smcd_pkg::SMCD_IDLE);
	wire [31:0] stat_w  = {20'h00000, cnt_r, wrsv_r, wmask_r, err_ovf_r,
	                       err_ord_r, err_al_r, err_id_r, done_r, busy};
	wire [7:0]  ra      = HADDR[7:0];
	wire [31:0] rd_mux  = (ra == `SMCD_OFS_HDR2) ? hdr2_r :
	                      (ra == `SMCD_OFS_CFG)  ? cfg_r :
	                      (ra == `SMCD_OFS_STAT) ? stat_w :
	                      (ra == `SMCD_OFS_SEL)  ? {16'h0000, lastb_r, sel_r} :
	                      32'h0000_0000;

	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = rdata_r;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wpend_r <= 1'b0;
			wa_r    <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else begin
			wpend_r <= ahb_acc & HWRITE;
			if (ahb_acc)
				wa_r <= HADDR[7:0];
			if (ahb_acc && !HWRITE)
				rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hdr2_r <= `SMCD_HDR2_RST;
			cfg_r  <= `SMCD_CFG_RST;
		end else begin
			if (wr_hdr2 && !busy)
				hdr2_r <= HWDATA;
			if (wr_cfg && !busy)
				cfg_r <= HWDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table walk decisions
	wire start_w  = wr_ctrl & HWDATA[`SMCD_CTRL_START] & !busy;
	wire id_ok    = (hdr2_r[`SMCD_HDR_ID] == `SMCD_ID_MSB_VAL);
	wire al_ok    = (hdr2_r[`SMCD_HDR_ALIGN] == 2'b00);
	wire start_ok = start_w & id_ok & al_ok;
	wire eval_w   = (st_r == smcd_pkg::SMCD_EVAL);
	wire ev_desc  = eval_w & ~kind_r & ~wsel_r;
	wire is_map   = word_r[`SMCD_D_TYPE];
	wire ev_map   = ev_desc & is_map;
	wire ev_ord   = ev_desc & ~is_map & last_r;
	wire ev_ovf   = ev_desc & ~is_map & ~last_r & (cnt_r == `SMCD_SEL_MAX);
	wire ev_cmd   = ev_desc & ~is_map & ~last_r & ~ev_ovf;
	wire ev_det   = eval_w & ~kind_r & wsel_r;
	wire ev_bit   = eval_w & kind_r;
	wire launch   = start_ok | ev_cmd | ev_det | ev_bit;
	wire det_bit  = |(word_r[31:24] & desc_r[`SMCD_D_MASK]);
	wire rsv_ok   = (&word_r[`SMCD_D_RSV_HI]) & (&word_r[`SMCD_D_RSV_LO]);

	////////////////////////////////////////////////////////////////////////
	// Launch fields for the next flash command
	wire [23:0] l_ptr  = start_ok ? hdr2_r[`SMCD_HDR_PTR] :
	                     ptr_r + (ev_bit ? 24'd8 : 24'd4);
	wire [3:0]  d_lat  = desc_r[`SMCD_D_LAT];
	wire [7:0]  l_op   = ev_det ? desc_r[`SMCD_D_OPC] : cfg_r[`SMCD_CFG_TBL_OP];
	wire [31:0] l_addr = ev_det ? word_r : {8'h00, l_ptr};
	wire [2:0]  l_nadr = ev_det ?
	                     alen_bytes(desc_r[`SMCD_D_ALEN],
	                                cfg_r[`SMCD_CFG_ADDR4]) : 3'd3;
	wire [3:0]  l_ndum = !ev_det ? cfg_r[`SMCD_CFG_TBL_DUM] :
	                     (d_lat == `SMCD_LAT_VAR) ? cfg_r[`SMCD_CFG_LAT] :
	                     d_lat;                              // R14
	wire [2:0]  l_ndat = ev_det ? 3'd1 : 3'd4;
	wire [31:0] l_ash  = (l_nadr == 3'd3) ? {l_addr[23:0], 8'h00} : l_addr;

	////////////////////////////////////////////////////////////////////////
	// Serial engine
	wire xfer    = (st_r == smcd_pkg::SMCD_OP) | (st_r == smcd_pkg::SMCD_ADR) |
	               (st_r == smcd_pkg::SMCD_DUM) | (st_r == smcd_pkg::SMCD_DAT);
	wire spi_go  = xfer & ~wait_r;
	wire [3:0] spi_n  = (st_r == smcd_pkg::SMCD_DUM) ? ndum_r : 4'd8;
	wire [7:0] spi_tx = (st_r == smcd_pkg::SMCD_OP)  ? op_r :
	                    (st_r == smcd_pkg::SMCD_ADR) ? ash_r[31:24] : 8'h00;
	wire       go_dum = (ndum_r != 4'h0);

	smcd_spi #(
		.HALF  (SCK_HALF)
	) u_spi (
		.clk   (CLK),
		.rst_n (RSTN),
		.go    (spi_go),
		.nbits (spi_n),
		.txd   (spi_tx),
		.done  (spi_done),
		.rxd   (spi_rx),
		.sck   (FL_SCK),
		.mosi  (FL_MOSI),
		.miso  (FL_MISO)
	);

	assign FL_CSN = csn_r;

	////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r   <= smcd_pkg::SMCD_IDLE;
			wait_r <= 1'b0;
			csn_r  <= 1'b1;
			kind_r <= 1'b0;
			wsel_r <= 1'b0;
			op_r   <= 8'h00;
			ash_r  <= 32'h0000_0000;
			nadr_r <= 3'd0;
			ndum_r <= 4'h0;
			ndat_r <= 3'd0;
			bcnt_r <= 3'd0;
			word_r <= 32'h0000_0000;
			gap_r  <= 8'h00;
		end else begin
			if (spi_go)
				wait_r <= 1'b1;
			else if (spi_done)
				wait_r <= 1'b0;
			if (launch) begin
				st_r   <= smcd_pkg::SMCD_OP;
				csn_r  <= 1'b0;
				op_r   <= l_op;                   // R15
				ash_r  <= l_ash;                  // R18
				nadr_r <= l_nadr;                 // R10
				ndum_r <= l_ndum;                 // R13
				ndat_r <= l_ndat;                 // R7
				kind_r <= ev_det;
				wsel_r <= ev_cmd;
			end else begin
				unique case (st_r)
					smcd_pkg::SMCD_IDLE: begin
						csn_r <= 1'b1;
					end
					smcd_pkg::SMCD_OP: begin
						if (spi_done && nadr_r != 3'd0) begin
							st_r   <= smcd_pkg::SMCD_ADR;
							bcnt_r <= nadr_r;
						end else if (spi_done) begin
							st_r   <= go_dum ? smcd_pkg::SMCD_DUM
							                 : smcd_pkg::SMCD_DAT;
							bcnt_r <= ndat_r;
						end
					end
					smcd_pkg::SMCD_ADR: begin
						if (spi_done) begin
							ash_r  <= {ash_r[23:0], 8'h00};   // R21
							bcnt_r <= bcnt_r - 3'd1;
							if (bcnt_r == 3'd1) begin
								st_r   <= go_dum ? smcd_pkg::SMCD_DUM
								                 : smcd_pkg::SMCD_DAT;
								bcnt_r <= ndat_r;
							end
						end
					end
					smcd_pkg::SMCD_DUM: begin
						if (spi_done)
							st_r <= smcd_pkg::SMCD_DAT;
					end
					smcd_pkg::SMCD_DAT: begin
						if (spi_done) begin
							word_r <= {spi_rx, word_r[31:8]};
							bcnt_r <= bcnt_r - 3'd1;
							if (bcnt_r == 3'd1) begin
								st_r  <= smcd_pkg::SMCD_GAP;   // R21
								csn_r <= 1'b1;
								gap_r <= 8'h00;
							end
						end
					end
					smcd_pkg::SMCD_GAP: begin
						gap_r <= gap_r + 8'h01;
						if (gap_r >= 8'(CS_GAP - 1))
							st_r <= smcd_pkg::SMCD_EVAL;
					end
					smcd_pkg::SMCD_EVAL: begin
						st_r <= smcd_pkg::SMCD_DONE;     // R5
					end
					smcd_pkg::SMCD_DONE: begin
						st_r <= smcd_pkg::SMCD_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Walk state, selector and status flags
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ptr_r   <= 24'h000000;
			desc_r  <= 32'h0000_0000;
			sel_r   <= 8'h00;
			cnt_r   <= 4'h0;
			last_r  <= 1'b0;
			lastb_r <= 8'h00;
		end else if (start_w) begin
			ptr_r   <= l_ptr;                    // R2
			sel_r   <= 8'h00;                    // R20
			cnt_r   <= 4'h0;
			last_r  <= 1'b0;
		end else if (ev_cmd) begin
			desc_r  <= word_r;                   // R16
		end else if (ev_bit) begin
			ptr_r   <= l_ptr;                    // R6
			sel_r   <= {sel_r[6:0], det_bit};    // R19
			cnt_r   <= cnt_r + 4'h1;             // R8
			last_r  <= desc_r[`SMCD_D_LAST];     // R17
			lastb_r <= word_r[31:24];            // R9
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			done_r    <= 1'b0;
			err_id_r  <= 1'b0;
			err_al_r  <= 1'b0;
			err_ord_r <= 1'b0;
			err_ovf_r <= 1'b0;
			wmask_r   <= 1'b0;
			wrsv_r    <= 1'b0;
		end else if (start_w) begin
			done_r    <= ~start_ok;
			err_id_r  <= ~id_ok;                 // R1
			err_al_r  <= ~al_ok;                 // R2
			err_ord_r <= 1'b0;
			err_ovf_r <= 1'b0;
			wmask_r   <= 1'b0;
			wrsv_r    <= 1'b0;
		end else begin
			if (st_r == smcd_pkg::SMCD_DONE)
				done_r <= 1'b1;
			if (ev_ord)
				err_ord_r <= 1'b1;               // R5
			if (ev_ovf)
				err_ovf_r <= 1'b1;               // R19
			if (ev_cmd && !onehot8(word_r[`SMCD_D_MASK]))
				wmask_r <= 1'b1;                 // R9
			if (ev_cmd && !rsv_ok)
				wrsv_r <= 1'b1;                  // R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	chk_bad_id_flag: assert property ( // R1
		start_w && !id_ok |=> err_id_r && done_r && !busy)
		else $error("bad table identifier not flagged");
	chk_align_flag: assert property ( // R2
		start_w && id_ok && !al_ok |=> err_al_r && !busy)
		else $error("misaligned table pointer not flagged");
	chk_fixed_alen: assert property ( // R10
		ev_det && desc_r[23:22] != 2'b11 |=>
		nadr_r == (desc_r[23] ? 3'd4 : desc_r[22] ? 3'd3 : 3'd0))
		else $error("address length does not follow descriptor");
	chk_var_alen: assert property ( // R11
		ev_det && desc_r[23:22] == 2'b11 |=>
		nadr_r == (cfg_r[4] ? 3'd4 : 3'd3))
		else $error("variable address length not from configuration");
	chk_latency: assert property ( // R13
		ev_det && desc_r[19:16] != 4'hf |=> ndum_r == $past(desc_r[19:16]))
		else $error("wait cycles do not follow descriptor");
	chk_var_latency: assert property ( // R14
		ev_det && desc_r[19:16] == 4'hf |=> ndum_r == $past(cfg_r[3:0]))
		else $error("variable latency not from configuration");
	chk_det_opcode: assert property ( // R15
		ev_det |=> op_r == desc_r[15:8] && ndat_r == 3'd1 && !csn_r)
		else $error("detection command opcode or length wrong");
	chk_sel_shift: assert property ( // R19
		ev_bit |=> sel_r == {$past(sel_r[6:0]), $past(det_bit)})
		else $error("selector did not shift in detected bit");
	chk_ptr_step: assert property ( // R6
		ev_bit |=> ptr_r == $past(ptr_r) + 24'd8)
		else $error("pointer did not advance two words");
	chk_map_ends: assert property ( // R5
		ev_map |=> st_r == smcd_pkg::SMCD_DONE ##1 done_r && !busy)
		else $error("map descriptor did not end the walk");
	chk_no_cmd_zero: assert property ( // R20
		ev_map && cnt_r == 4'h0 |-> sel_r == 8'h00)
		else $error("selector not zero without commands");
	chk_cs_frame: assert property ( // R21
		st_r == smcd_pkg::SMCD_OP && $past(st_r) == smcd_pkg::SMCD_IDLE
		|-> !csn_r ##1 !csn_r [*3])
		else $error("chip select not held for command");

	cov_no_commands: cover property (ev_map && cnt_r == 4'h0);
	cov_two_commands: cover property (ev_map && cnt_r == 4'h2);
	cov_four_byte: cover property (ev_det && l_nadr == 3'd4);
	cov_bad_id: cover property (start_w && !id_ok);

endmodule

// *** core/smcd_defs.svh ***
// Constants of the sector map configuration detector: offsets, fields,
// reset values and timing counts. Included by the controller module.
`ifndef SMCD_DEFS_SVH
`define SMCD_DEFS_SVH

// Register offsets (byte addresses, one word each)
`define SMCD_OFS_CTRL    8'h00
`define SMCD_OFS_HDR2    8'h04
`define SMCD_OFS_CFG     8'h08
`define SMCD_OFS_STAT    8'h0c
`define SMCD_OFS_SEL     8'h10

// Register reset values
`define SMCD_HDR2_RST    32'h0000_0000
`define SMCD_CFG_RST     32'h0000_0300

// Control and configuration fields
`define SMCD_CTRL_START  0
`define SMCD_CFG_LAT     3:0
`define SMCD_CFG_ADDR4   4
`define SMCD_CFG_TBL_OP  15:8
`define SMCD_CFG_TBL_DUM 19:16

// Header and descriptor fields
`define SMCD_HDR_ID      31:24
`define SMCD_HDR_PTR     23:0
`define SMCD_HDR_ALIGN   1:0
`define SMCD_ID_MSB_VAL  8'hff
`define SMCD_D_MASK      31:24
`define SMCD_D_ALEN      23:22
`define SMCD_D_RSV_HI    21:20
`define SMCD_D_LAT       19:16
`define SMCD_D_OPC       15:8
`define SMCD_D_RSV_LO    7:2
`define SMCD_D_TYPE      1
`define SMCD_D_LAST      0
`define SMCD_ALEN_NONE   2'b00
`define SMCD_ALEN_3      2'b01
`define SMCD_ALEN_4      2'b10
`define SMCD_LAT_VAR     4'hf
`define SMCD_SEL_MAX     4'h8

// Timing: chip select high time between commands
`define SMCD_CLK_MHZ     40
`define SMCD_CS_GAP_NS   100
`define SMCD_CS_GAP_CYC  ((`SMCD_CS_GAP_NS * `SMCD_CLK_MHZ + 999) / 1000)

`endif

// *** core/smcd_pkg.sv ***
// Types of the sector map configuration detector.
// Assumes nothing of its surroundings.
package smcd_pkg;

	// Sequencer states, Gray coded along the command path
	typedef enum logic [2:0] {
		SMCD_IDLE = 3'b000,
		SMCD_OP   = 3'b001,
		SMCD_ADR  = 3'b011,
		SMCD_DUM  = 3'b010,
		SMCD_DAT  = 3'b110,
		SMCD_GAP  = 3'b111,
		SMCD_EVAL = 3'b101,
		SMCD_DONE = 3'b100
	} smcd_state_t;

endpackage

// *** core/smcd_spi.sv ***
// Serial shifter: sends and receives up to fifteen bits, MSB first.
// Assumes one clock domain; the data input comes from a pin.
`timescale 1ns/1ps

module smcd_spi #(
	parameter int HALF = 4
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Request and answer
	input  wire logic       go,
	input  wire logic [3:0] nbits,
	input  wire logic [7:0] txd,
	output logic            done,
	output logic [7:0]      rxd,
	// Serial pins
	output logic            sck,
	output logic            mosi,
	input  wire logic       miso
);

	logic [7:0] cnt_r;
	logic [3:0] bits_r;
	logic [7:0] sh_r;
	logic [7:0] rx_r;
	logic       act_r;
	logic       sck_r;
	logic       mosi_r;
	logic       done_r;
	logic       s1_r;
	logic       s2_r;
	wire        half_end = (cnt_r == 8'(HALF - 1));

	assign done = done_r;
	assign rxd  = rx_r;
	assign sck  = sck_r;
	assign mosi = mosi_r;

	////////////////////////////////////////////////////////////////////////
	// Input synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= miso;
			s2_r <= s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock divider and shifter; sample at the end of the high phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= 8'h00;
			bits_r <= 4'h0;
			sh_r   <= 8'h00;
			rx_r   <= 8'h00;
			act_r  <= 1'b0;
			sck_r  <= 1'b0;
			mosi_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (go && !act_r) begin
				act_r  <= 1'b1;
				bits_r <= nbits;
				sh_r   <= txd;
				mosi_r <= txd[7];
				cnt_r  <= 8'h00;
			end else if (act_r && !half_end) begin
				cnt_r <= cnt_r + 8'h01;
			end else if (act_r) begin
				cnt_r <= 8'h00;
				sck_r <= ~sck_r;
				if (sck_r) begin
					rx_r   <= {rx_r[6:0], s2_r};
					sh_r   <= {sh_r[6:0], 1'b0};
					mosi_r <= sh_r[6];
					bits_r <= bits_r - 4'h1;
					if (bits_r == 4'h1) begin
						act_r  <= 1'b0;
						done_r <= 1'b1;
					end
				end
			end
		end
	end

endmodule

// *** verification/smcd_flash_mdl.sv ***
// Behavioural serial flash: sector map table bytes and config registers.
// Assumes one data line, clock idle low, data changed after falling edge.
`timescale 1ns/1ps

module smcd_flash_mdl (
	// Serial pins
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	output logic      miso
);
	logic [7:0]  mem [0:255];
	int          alen_of [0:255];
	int          lat_of [0:255];
	logic [7:0]  reg_of [0:255];
	logic [7:0]  lg_op [0:63];
	logic [31:0] lg_adr [0:63];
	int          lg_clk [0:63];
	int          nfr;
	int          bc;
	int          ds;
	int          k;
	logic [7:0]  op;
	logic [31:0] adr;
	logic [7:0]  byt;

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'hff;
			alen_of[i] = 3;
			lat_of[i] = 0;
			reg_of[i] = 8'h00;
		end
		nfr = 0;
		bc = 0;
		miso = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Frame start
	always @(negedge cs_n) begin
		bc = 0;
		op = 8'h00;
		adr = 32'h0;
	end

	// Opcode then address, MSB first
	always @(posedge sck) begin
		if (!cs_n) begin
			if (bc < 8)
				op = {op[6:0], mosi};
			else if (bc < 8 + 8 * alen_of[op])
				adr = {adr[30:0], mosi};
			bc = bc + 1;
		end
	end

	// Answer after latency: table stream or one register byte
	always @(negedge sck) begin
		if (!cs_n) begin
			ds = 8 + 8 * alen_of[op] + lat_of[op];
			if (bc >= ds) begin
				k = bc - ds;
				if (op == 8'h03)
					byt = mem[8'(adr + 32'(k / 8))];
				else
					byt = reg_of[op];
				miso = byt[7 - k % 8];
			end else begin
				miso = ~miso;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame end: log and toggle the data line
	always @(posedge cs_n) begin
		if (nfr < 64) begin
			lg_op[nfr] = op;
			lg_adr[nfr] = adr;
			lg_clk[nfr] = bc;
			nfr = nfr + 1;
		end
		miso = ~miso;
	end
endmodule

// *** verification/tb.sv ***
// Testbench of the sector map configuration detector.
// Assumes the flash model beside it and an AHB-Lite master of its own.
`timescale 1ns/1ps

module tb;
	logic        CLK;
	logic        RSTN;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic [31:0] HRDATA;
	logic        FL_SCK;
	logic        FL_CSN;
	logic        FL_MOSI;
	logic        FL_MISO;
	logic [31:0] rd;
	logic [31:0] st;
	int          fail_count;
	int          cmp_count;

	smcd_ctrl dut_u (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.HRDATA(HRDATA), .FL_SCK(FL_SCK), .FL_CSN(FL_CSN),
		.FL_MOSI(FL_MOSI), .FL_MISO(FL_MISO));
	smcd_flash_mdl flash_u (.sck(FL_SCK), .cs_n(FL_CSN), .mosi(FL_MOSI),
		.miso(FL_MISO));

	always #12.5 CLK = ~CLK;

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (HREADYOUT !== 1'b1) begin
			chk(32'h0, 32'h1);
			stop_test;
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		wait_rdy;
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= wd;
		wait_rdy;
		rd = HRDATA;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, HRESP}, 32'h0);
	endtask

	task automatic put_w(input logic [7:0] a, input logic [31:0] w);
		for (int i = 0; i < 4; i++)
			flash_u.mem[8'(a + 8'(i))] = w[8*i +: 8];
	endtask

	function automatic logic [31:0] cmdw(input logic [7:0] m,
		input logic [1:0] al, input logic [3:0] lt, input logic [7:0] o,
		input logic last);
		return {m, al, 2'b11, lt, o, 6'h3f, 1'b0, last};
	endfunction

	task automatic cfg(input logic [7:0] o, input int na, input int lt,
		input logic [7:0] v);
		flash_u.alen_of[o] = na;
		flash_u.lat_of[o] = lt;
		flash_u.reg_of[o] = v;
	endtask

	task automatic frm(input int i, input logic [7:0] o,
		input logic [31:0] a, input int n);
		chk({24'h0, flash_u.lg_op[i]}, {24'h0, o});
		chk(flash_u.lg_adr[i], a);
		chk(32'(flash_u.lg_clk[i]), 32'(n));
	endtask

	// Walk the table; busy write to HDR2 must be ignored
	task automatic run(input logic [31:0] hdr);
		int n;
		ahb(1'b1, 8'h04, hdr);
		flash_u.nfr = 0;
		ahb(1'b1, 8'h00, 32'h1);
		ahb(1'b0, 8'h0c, 32'h0);
		ahb(1'b1, 8'h04, 32'h0);
		n = 0;
		do begin
			ahb(1'b0, 8'h0c, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 20000);
		st = rd;
		if (rd[1:0] !== 2'b10) begin
			chk(rd, 32'h2);
			stop_test;
		end
		rdchk(8'h04, (hdr[31:24] == 8'hff && hdr[1:0] == 2'b00) ? hdr : 0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		CLK = 1'b0;
		RSTN = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'b00;
		HWRITE = 1'b0;
		HSIZE = 3'b010;
		HWDATA = 32'h0;
		fail_count = 0;
		cmp_count = 0;
		repeat (5) @(posedge CLK);
		chk({30'h0, FL_CSN, FL_SCK}, 32'h2);
		RSTN <= 1'b1;
		@(posedge CLK);
		// Reset values and unmapped offset
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'h0000_0300);
		rdchk(8'h0c, 32'h0);
		rdchk(8'h10, 32'h0);
		ahb(1'b1, 8'h20, 32'hffff_ffff);
		rdchk(8'h20, 32'h0);
		rdchk(8'h00, 32'h0);
		// Bad identifier, then misaligned pointer
		run(32'hfe00_0010);
		chk(st, 32'h0000_0006);
		chk(32'(flash_u.nfr), 32'h0);
		run(32'hff00_0012);
		chk(st, 32'h0000_000a);
		chk(32'(flash_u.nfr), 32'h0);
		// Three commands: no, 3 and variable address; fixed, Fh, 14 waits
		ahb(1'b1, 8'h08, 32'h0000_0315);
		put_w(8'h20, cmdw(8'h04, 2'b00, 4'h2, 8'h65, 1'b0));
		put_w(8'h24, 32'h1122_3344);
		put_w(8'h28, cmdw(8'h80, 2'b01, 4'hf, 8'h35, 1'b0));
		put_w(8'h2c, 32'h0012_3456);
		put_w(8'h30, cmdw(8'h01, 2'b11, 4'he, 8'h15, 1'b1));
		put_w(8'h34, 32'ha1b2_c3d4);
		put_w(8'h38, 32'hff00_00ff);
		cfg(8'h65, 0, 2, 8'h04);
		cfg(8'h35, 3, 5, 8'h7f);
		cfg(8'h15, 4, 14, 8'h81);
		run(32'hff00_0020);
		chk(st, 32'h0000_0302);
		rdchk(8'h10, 32'h0000_8105);
		for (int k = 0; k < 10; k += 3) begin
			frm(k, 8'h03, 32'h20 + 32'(8 * (k / 3)), 64);
			if (k < 9)
				frm(k + 1, 8'h03, 32'h24 + 32'(8 * (k / 3)), 64);
		end
		frm(2, 8'h65, 32'h0, 18);
		frm(5, 8'h35, 32'h0012_3456, 45);
		frm(8, 8'h15, 32'ha1b2_c3d4, 62);
		chk(32'(flash_u.nfr), 32'd10);
		// No command descriptors
		put_w(8'h40, 32'hff00_00ff);
		run(32'hff00_0040);
		chk(st, 32'h0000_0002);
		ahb(1'b0, 8'h10, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h0);
		frm(0, 8'h03, 32'h40, 64);
		chk(32'(flash_u.nfr), 32'd1);
		// Bad mask and reserved bits, then a command after the last
		put_w(8'h50, cmdw(8'h06, 2'b11, 4'h0, 8'h71, 1'b1) & 32'hffcf_ff03);
		put_w(8'h54, 32'h99ab_cdef);
		put_w(8'h58, cmdw(8'h01, 2'b00, 4'h0, 8'h71, 1'b1));
		put_w(8'h5c, 32'h0);
		cfg(8'h71, 3, 0, 8'h02);
		ahb(1'b1, 8'h08, 32'h0000_0300);
		run(32'hff00_0050);
		chk(st, 32'h0000_01d2);
		ahb(1'b0, 8'h10, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h1);
		frm(2, 8'h71, 32'h00ab_cdef, 40);
		// Nine commands: selector stops at eight bits
		for (int i = 0; i < 9; i++) begin
			put_w(8'h80 + 8'(8 * i), cmdw((i % 2) ? 8'h02 : 8'h01, 2'b10,
				4'h0, 8'h05, 1'b0));
			put_w(8'h84 + 8'(8 * i), 32'h5a00_0000 + 32'(i));
		end
		cfg(8'h05, 4, 0, 8'h01);
		run(32'hff00_0080);
		chk(st, 32'h0000_0822);
		frm(2, 8'h05, 32'h5a00_0000, 48);
		frm(23, 8'h05, 32'h5a00_0007, 48);
		chk(32'(flash_u.nfr), 32'd25);
		ahb(1'b0, 8'h10, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h0000_00aa);
		stop_test;
	end
endmodule
